/* hdl/pccm_pkg.sv */
// Constants for the fast pulse counter compare-match block.
// Assumes an APB slave with 8-bit byte addresses and 32-bit data.
package pccm_pkg;
	localparam int unsigned ADDR_W       = 8;
	localparam int unsigned DATA_W       = 32;
	localparam int unsigned COUNT_W      = 24;
	localparam int unsigned STAT_W       = 8;

	localparam logic [23:0] COUNT_MAX    = 24'hFFFFFF;
	localparam logic [23:0] COUNT_RST    = 24'h000000;

	// Register byte offsets
	localparam logic [7:0]  OFS_CONFIG   = 8'h00;
	localparam logic [7:0]  OFS_PRESET   = 8'h04;
	localparam logic [7:0]  OFS_SETPOINT = 8'h08;
	localparam logic [7:0]  OFS_STATUS   = 8'h0C;
	localparam logic [7:0]  OFS_COUNT    = 8'h10;
	localparam logic [7:0]  OFS_INT_STAT = 8'h14;
	localparam logic [7:0]  OFS_INT_CLR  = 8'h18;
	localparam logic [7:0]  OFS_INT_EN   = 8'h1C;

	// Config register fields
	localparam int unsigned CFG_PHASE_BIT  = 0;
	localparam int unsigned CFG_ENABLE_BIT = 4;
	localparam int unsigned CFG_SCALE_LSB  = 8;
	localparam int unsigned CFG_SCALE_W    = 3;
	localparam logic [2:0]  SCALE_RST      = 3'h1;

	// Status register fields
	localparam int unsigned STS_DONE_BIT   = 0;
	localparam int unsigned STS_CODE_LSB   = 8;

	// Count register fields
	localparam int unsigned COUNT_CARRY_BIT = 24;

	// Interrupt bits
	localparam int unsigned IRQ_W          = 2;
	localparam int unsigned IRQ_MATCH      = 0;
	localparam int unsigned IRQ_ERROR      = 1;

	// Status codes
	localparam logic [7:0]  STAT_OK        = 8'h00;
	localparam logic [7:0]  STAT_NO_COUNTER = 8'h01;
	localparam logic [7:0]  STAT_BAD_SCALE  = 8'h02;
	localparam logic [7:0]  STAT_RANGE     = 8'h03;
	localparam logic [7:0]  STAT_DISABLED  = 8'h04;
endpackage

/* hdl/pccm_match.sv */
// Equality detector that fires once on entry into count == setpoint.
// Assumes count and setpoint are registered in the pclk domain.
`timescale 1ns/1ns
`default_nettype none
module pccm_match (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        enable,
	input  wire logic [pccm_pkg::COUNT_W-1:0] count,
	input  wire logic [pccm_pkg::COUNT_W-1:0] setpoint,
	output logic                             match_pulse
);
	import pccm_pkg::*;

	logic eq_reg;
	logic eq_next;
	logic pulse_reg;
	logic pulse_next;

	always_comb begin
		eq_next    = enable && (count == setpoint);
		pulse_next = eq_next && !eq_reg;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eq_reg    <= 1'b0;
			pulse_reg <= 1'b0;
		end else begin
			eq_reg    <= eq_next;
			pulse_reg <= pulse_next;
		end
	end

	assign match_pulse = pulse_reg;
endmodule
`default_nettype wire

/* hdl/pccm_top.sv */
// APB-controlled compare-match and status block of a 24-bit pulse counter.
// Assumes count pulses arrive synchronous to pclk, one per cycle at most.
//
// Function
// - Setpoint is unsigned 0 to 16,777,215; requester keeps values in range.
// - Count equal to setpoint while the counter is enabled raises a match event that sets the match interrupt status bit.
// - Done set after an error-free request; stays low on any error.
// - Status 00 on success, 01 when the variant has no pulse counter.
// - Status 02 when two-phase configuration has multiplier other than 1, 2, 4.
// - Status 03 when preset or setpoint lies outside 0 to 16,777,215.
// - Status 04 and no preset applied when counter is disabled.
// - Counter enable low holds the running count at zero.
// - Running count readable as unsigned 0 to 16,777,215 with a carry flag.
`timescale 1ns/1ns
`default_nettype none
module pccm_top #(
	parameter bit HAS_COUNTER = 1'b1
) (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [pccm_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [pccm_pkg::DATA_W-1:0]  pwdata,
	output logic      [pccm_pkg::DATA_W-1:0]  prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        count_step_in,
	input  wire logic                        count_down_in,
	output logic      [pccm_pkg::COUNT_W-1:0] running_count_out,
	output logic                             carry_flag,
	output logic      [2:0]                  count_multiplier,
	output logic                             counter_enable_input,
	output logic                             match_event,
	output logic                             irq
);
	import pccm_pkg::*;

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		case (a)
			OFS_CONFIG, OFS_PRESET, OFS_SETPOINT, OFS_STATUS,
			OFS_COUNT, OFS_INT_STAT, OFS_INT_CLR, OFS_INT_EN: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	function automatic logic scale_ok(input logic [2:0] m);
		scale_ok = (m == 3'h1) || (m == 3'h2) || (m == 3'h4);
	endfunction

	// Bus strobes
	logic wr_stb;
	logic rd_setup;
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !is_mapped(paddr);
	assign wr_stb   = psel && penable && pwrite && is_mapped(paddr);
	assign rd_setup = psel && !penable && !pwrite;

	// Register state
	logic                 phase_reg;
	logic                 phase_next;
	logic                 enable_reg;
	logic                 enable_next;
	logic [2:0]           scale_reg;
	logic [2:0]           scale_next;
	logic [COUNT_W-1:0]   preset_reg;
	logic [COUNT_W-1:0]   preset_next;
	logic [COUNT_W-1:0]   setpoint_reg;
	logic [COUNT_W-1:0]   setpoint_next;
	logic                 done_reg;
	logic                 done_next;
	logic [STAT_W-1:0]    stat_reg;
	logic [STAT_W-1:0]    stat_next;
	logic [IRQ_W-1:0]     int_stat_reg;
	logic [IRQ_W-1:0]     int_stat_next;
	logic [IRQ_W-1:0]     int_en_reg;
	logic [IRQ_W-1:0]     int_en_next;
	logic [DATA_W-1:0]    prdata_reg;
	logic [DATA_W-1:0]    prdata_next;
	logic                 preset_apply;
	logic                 req_error;

	// Counter state
	logic [COUNT_W-1:0]   count_reg;
	logic [COUNT_W-1:0]   count_next;
	logic                 carry_reg;
	logic                 carry_next;
	logic                 match_pulse;

	// Requests and register writes
	always_comb begin
		phase_next    = phase_reg;
		enable_next   = enable_reg;
		scale_next    = scale_reg;
		preset_next   = preset_reg;
		setpoint_next = setpoint_reg;
		done_next     = done_reg;
		stat_next     = stat_reg;
		int_en_next   = int_en_reg;
		preset_apply  = 1'b0;
		req_error     = 1'b0;
		if (wr_stb) begin
			case (paddr)
				OFS_CONFIG: begin
					if (!HAS_COUNTER) begin
						stat_next = STAT_NO_COUNTER;
					end else if (pwdata[CFG_PHASE_BIT] &&
							!scale_ok(pwdata[CFG_SCALE_LSB +: CFG_SCALE_W])) begin
						stat_next = STAT_BAD_SCALE;
					end else begin
						stat_next   = STAT_OK;
						phase_next  = pwdata[CFG_PHASE_BIT];
						enable_next = pwdata[CFG_ENABLE_BIT];
						scale_next  = pwdata[CFG_PHASE_BIT] ?
							pwdata[CFG_SCALE_LSB +: CFG_SCALE_W] : SCALE_RST;
					end
				end
				OFS_PRESET: begin
					if (!HAS_COUNTER) begin
						stat_next = STAT_NO_COUNTER;
					end else if (pwdata[DATA_W-1:COUNT_W] != 8'h00) begin
						stat_next = STAT_RANGE;
					end else if (!enable_reg) begin
						stat_next = STAT_DISABLED;
					end else begin
						stat_next    = STAT_OK;
						preset_next  = pwdata[COUNT_W-1:0];
						preset_apply = 1'b1;
					end
				end
				OFS_SETPOINT: begin
					if (!HAS_COUNTER) begin
						stat_next = STAT_NO_COUNTER;
					end else if (pwdata[DATA_W-1:COUNT_W] != 8'h00) begin
						stat_next = STAT_RANGE;
					end else begin
						stat_next     = STAT_OK;
						setpoint_next = pwdata[COUNT_W-1:0];
					end
				end
				OFS_INT_EN: begin
					int_en_next = pwdata[IRQ_W-1:0];
				end
				default: begin
				end
			endcase
			if (paddr == OFS_CONFIG || paddr == OFS_PRESET || paddr == OFS_SETPOINT) begin
				done_next = (stat_next == STAT_OK);
				req_error = (stat_next != STAT_OK);
			end
		end
	end

	// Sticky interrupt status, set wins over clear
	always_comb begin
		int_stat_next = int_stat_reg;
		if (wr_stb && paddr == OFS_INT_CLR) begin
			int_stat_next = int_stat_reg & ~pwdata[IRQ_W-1:0];
		end
		if (match_pulse) begin
			int_stat_next[IRQ_MATCH] = 1'b1;
		end
		if (req_error) begin
			int_stat_next[IRQ_ERROR] = 1'b1;
		end
	end

	// Read data captured in the setup phase
	always_comb begin
		prdata_next = prdata_reg;
		if (rd_setup) begin
			prdata_next = '0;
			case (paddr)
				OFS_CONFIG: begin
					prdata_next[CFG_PHASE_BIT]                 = phase_reg;
					prdata_next[CFG_ENABLE_BIT]                = enable_reg;
					prdata_next[CFG_SCALE_LSB +: CFG_SCALE_W]  = scale_reg;
				end
				OFS_PRESET:   prdata_next[COUNT_W-1:0] = preset_reg;
				OFS_SETPOINT: prdata_next[COUNT_W-1:0] = setpoint_reg;
				OFS_STATUS: begin
					prdata_next[STS_DONE_BIT]              = done_reg;
					prdata_next[STS_CODE_LSB +: STAT_W]    = stat_reg;
				end
				OFS_COUNT: begin
					prdata_next[COUNT_W-1:0]   = count_reg;
					prdata_next[COUNT_CARRY_BIT] = carry_reg;
				end
				OFS_INT_STAT: prdata_next[IRQ_W-1:0] = int_stat_reg;
				OFS_INT_EN:   prdata_next[IRQ_W-1:0] = int_en_reg;
				default: begin
				end
			endcase
		end
	end

	// Running counter
	always_comb begin
		count_next = count_reg;
		carry_next = carry_reg;
		if (!enable_reg) begin
			count_next = COUNT_RST;
			carry_next = 1'b0;
		end else if (preset_apply) begin
			count_next = preset_next;
			carry_next = 1'b0;
		end else if (count_step_in) begin
			if (count_down_in) begin
				count_next = count_reg - 24'h000001;
				carry_next = carry_reg || (count_reg == COUNT_RST);
			end else begin
				count_next = count_reg + 24'h000001;
				carry_next = carry_reg || (count_reg == COUNT_MAX);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_reg    <= 1'b0;
			enable_reg   <= 1'b0;
			scale_reg    <= SCALE_RST;
			preset_reg   <= COUNT_RST;
			setpoint_reg <= COUNT_RST;
			done_reg     <= 1'b0;
			stat_reg     <= STAT_OK;
			int_stat_reg <= '0;
			int_en_reg   <= '0;
			prdata_reg   <= '0;
			count_reg    <= COUNT_RST;
			carry_reg    <= 1'b0;
		end else begin
			phase_reg    <= phase_next;
			enable_reg   <= enable_next;
			scale_reg    <= scale_next;
			preset_reg   <= preset_next;
			setpoint_reg <= setpoint_next;
			done_reg     <= done_next;
			stat_reg     <= stat_next;
			int_stat_reg <= int_stat_next;
			int_en_reg   <= int_en_next;
			prdata_reg   <= prdata_next;
			count_reg    <= count_next;
			carry_reg    <= carry_next;
		end
	end

	pccm_match u_match (
		.pclk        (pclk),
		.presetn     (presetn),
		.enable      (enable_reg),
		.count       (count_reg),
		.setpoint    (setpoint_reg),
		.match_pulse (match_pulse)
	);

	assign prdata               = prdata_reg;
	assign running_count_out    = count_reg;
	assign carry_flag           = carry_reg;
	assign count_multiplier     = scale_reg;
	assign counter_enable_input = enable_reg;
	assign match_event          = match_pulse;
	assign irq                  = |(int_stat_reg & int_en_reg);

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_match_equal: assert property (match_event |->
		$past(count_reg) == $past(setpoint_reg) && $past(enable_reg))
		else $error("match event without equality");
	a_match_once: assert property (match_event |=> !match_event)
		else $error("match event repeated");
	a_enable_clear: assert property (!enable_reg |=> count_reg == COUNT_RST)
		else $error("count not cleared while disabled");
	a_setpoint_load: assert property (wr_stb && paddr == OFS_SETPOINT && HAS_COUNTER
		&& pwdata[31:24] == 8'h00 |=> setpoint_reg == $past(pwdata[23:0])
		&& done_reg && stat_reg == STAT_OK)
		else $error("setpoint not loaded");
	a_done_error: assert property (req_error |=> !done_reg)
		else $error("done set after failed request");
	a_range_err: assert property (wr_stb && (paddr == OFS_SETPOINT || paddr == OFS_PRESET)
		&& HAS_COUNTER && pwdata[31:24] != 8'h00
		|=> stat_reg == STAT_RANGE && !done_reg && $stable(setpoint_reg))
		else $error("range error not reported");
	a_preset_off: assert property (wr_stb && paddr == OFS_PRESET && HAS_COUNTER
		&& pwdata[31:24] == 8'h00 && !enable_reg
		|=> stat_reg == STAT_DISABLED && !done_reg && count_reg == COUNT_RST)
		else $error("preset while disabled accepted");
	a_scale_bad: assert property (wr_stb && paddr == OFS_CONFIG && HAS_COUNTER
		&& pwdata[0] && !scale_ok(pwdata[10:8])
		|=> stat_reg == STAT_BAD_SCALE && $stable(scale_reg))
		else $error("bad multiplier accepted");
	a_no_counter: assert property (wr_stb && !HAS_COUNTER && (paddr == OFS_CONFIG
		|| paddr == OFS_PRESET || paddr == OFS_SETPOINT)
		|=> stat_reg == STAT_NO_COUNTER && !done_reg)
		else $error("missing counter not reported");
	a_count_read: assert property (rd_setup && paddr == OFS_COUNT
		|=> prdata[23:0] == $past(count_reg) && prdata[24] == $past(carry_reg))
		else $error("count read mismatch");

	c_match: cover property (match_event);
	c_range: cover property (wr_stb && paddr == OFS_SETPOINT && pwdata[31:24] != 8'h00);
	c_preset_off: cover property (wr_stb && paddr == OFS_PRESET && !enable_reg);
	c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

/* tb/pccm_top_bench.sv */
// Self-checking bench for the pulse counter compare-match block.
// Assumes pccm_pkg is compiled first; a second instance models the counterless variant.
`timescale 1ns/1ns
`default_nettype none
module pccm_top_bench;
	import pccm_pkg::*;
	logic                pclk = 1'b0;
	logic                presetn = 1'b0;
	logic                psel = 1'b0;
	logic                penable = 1'b0;
	logic                pwrite = 1'b0;
	logic [ADDR_W-1:0]   paddr = '0;
	logic [DATA_W-1:0]   pwdata = '0;
	logic [DATA_W-1:0]   prdata;
	logic [DATA_W-1:0]   prdata_nc;
	logic                pready;
	logic                pslverr;
	logic                count_step_in = 1'b0;
	logic                count_down_in = 1'b0;
	logic [COUNT_W-1:0]  running_count_out;
	logic                carry_flag;
	logic [2:0]          count_multiplier;
	logic                counter_enable_input;
	logic                match_event;
	logic                irq;
	logic [DATA_W-1:0]   rd;
	logic [DATA_W-1:0]   rd_nc;
	logic                err_seen;
	logic [2:0]          good_scale;
	int                  num_errors = 0;
	int                  n_compared = 0;
	int                  cycles = 0;
	int                  hits;

	always #25 pclk = ~pclk;

	pccm_top #(.HAS_COUNTER(1'b1)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .count_step_in(count_step_in),
		.count_down_in(count_down_in), .running_count_out(running_count_out),
		.carry_flag(carry_flag), .count_multiplier(count_multiplier),
		.counter_enable_input(counter_enable_input), .match_event(match_event), .irq(irq));

	// Counterless variant shares the bus; only its read data is observed
	pccm_top #(.HAS_COUNTER(1'b0)) DUT_NC (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_nc),
		.pready(), .pslverr(), .count_step_in(count_step_in), .count_down_in(count_down_in),
		.running_count_out(), .carry_flag(), .count_multiplier(), .counter_enable_input(),
		.match_event(), .irq());

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			num_errors = num_errors + 1;
			end_of_test();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One APB transfer; read data and slave error are taken at the pready edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		rd_nc = prdata_nc;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask

	function automatic logic [31:0] st(input logic [7:0] code, input logic done);
		return {16'h0000, code, 7'h00, done};
	endfunction

	task automatic step(input logic down);
		@(posedge pclk);
		count_step_in <= 1'b1;
		count_down_in <= down;
		@(posedge pclk);
		count_step_in <= 1'b0;
	endtask

	task automatic watch();
		hits = 0;
		repeat (8) begin
			@(posedge pclk);
			#1;
			if (match_event === 1'b1) hits++;
		end
	endtask

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk("count", 32'h0, {8'h00, running_count_out});
		chk("multiplier", 32'h1, {29'h0, count_multiplier});
		chk("irq", 32'h0, {31'h0, irq});
		chk("pready", 32'h1, {31'h0, pready});
		xfer(1'b1, OFS_PRESET, 32'h5);
		rd_chk("status", OFS_STATUS, st(STAT_DISABLED, 1'b0));
		chk("status nc", st(STAT_NO_COUNTER, 1'b0), rd_nc);
		chk("count", 32'h0, {8'h00, running_count_out});
		xfer(1'b1, OFS_CONFIG, 32'h10);
		rd_chk("status", OFS_STATUS, st(STAT_OK, 1'b1));
		chk("enable", 32'h1, {31'h0, counter_enable_input});
		good_scale = 3'h1;
		for (int m = 0; m < 8; m++) begin
			xfer(1'b1, OFS_CONFIG, 32'h11 | (m << 8));
			if (m == 1 || m == 2 || m == 4) begin
				good_scale = m[2:0];
				rd_chk("status", OFS_STATUS, st(STAT_OK, 1'b1));
			end else begin
				rd_chk("status", OFS_STATUS, st(STAT_BAD_SCALE, 1'b0));
			end
			chk("multiplier", {29'h0, good_scale}, {29'h0, count_multiplier});
		end
		rd_chk("config", OFS_CONFIG, 32'h00000411);
		xfer(1'b1, OFS_CONFIG, 32'h10);
		xfer(1'b1, OFS_INT_CLR, 32'h3);
		xfer(1'b1, OFS_PRESET, 32'h01000000);
		rd_chk("status", OFS_STATUS, st(STAT_RANGE, 1'b0));
		xfer(1'b1, OFS_SETPOINT, 32'h01000000);
		rd_chk("status", OFS_STATUS, st(STAT_RANGE, 1'b0));
		rd_chk("int stat", OFS_INT_STAT, 32'h2);
		xfer(1'b1, OFS_INT_CLR, 32'h3);
		xfer(1'b1, OFS_PRESET, 32'hFFFFFE);
		rd_chk("status", OFS_STATUS, st(STAT_OK, 1'b1));
		rd_chk("preset", OFS_PRESET, 32'h00FFFFFE);
		xfer(1'b1, OFS_SETPOINT, 32'hFFFFFF);
		rd_chk("status", OFS_STATUS, st(STAT_OK, 1'b1));
		rd_chk("setpoint", OFS_SETPOINT, 32'h00FFFFFF);
		xfer(1'b1, OFS_INT_EN, 32'h1);
		rd_chk("count", OFS_COUNT, 32'hFFFFFE);
		step(1'b0);
		watch();
		chk("match pulses", 32'h1, hits);
		watch();
		chk("match repeat", 32'h0, hits);
		chk("irq", 32'h1, {31'h0, irq});
		rd_chk("int stat", OFS_INT_STAT, 32'h1);
		xfer(1'b1, OFS_INT_EN, 32'h0);
		#1;
		chk("irq masked", 32'h0, {31'h0, irq});
		xfer(1'b1, OFS_INT_CLR, 32'h1);
		xfer(1'b1, OFS_INT_EN, 32'h1);
		#1;
		chk("irq cleared", 32'h0, {31'h0, irq});
		step(1'b0);
		rd_chk("count", OFS_COUNT, 32'h01000000);
		step(1'b1);
		watch();
		chk("match reentry", 32'h1, hits);
		chk("carry", 32'h1, {31'h0, carry_flag});
		xfer(1'b1, OFS_CONFIG, 32'h0);
		rd_chk("count", OFS_COUNT, 32'h0);
		step(1'b0);
		rd_chk("count", OFS_COUNT, 32'h0);
		rd_chk("unmapped", 8'h20, 32'h0);
		chk("pslverr", 32'h1, {31'h0, err_seen});
		end_of_test();
	end
endmodule
`default_nettype wire
